// >>> core/reset_ctl_pkg.sv
// package: constants, register map and types for the reset cause and brownout control block
package reset_ctl_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int BROWNOUT_MIN_DURATION_NS = 1000;
  localparam int PIN_FILTER_NS = 200;
  // least times round up to whole cycles
  localparam int BROWNOUT_MIN_CYC = (BROWNOUT_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_FILTER_CYC = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BROWNOUT_MIN_LAST = 8'(BROWNOUT_MIN_CYC - 1);
  localparam logic [7:0] PIN_FILTER_LAST = 8'(PIN_FILTER_CYC - 1);
  // power-up timer: 11-bit, 2048 low-frequency oscillator ticks
  localparam int PUT_WIDTH = 11;
  localparam logic [10:0] PUT_LAST = 11'h7FF;
  // oscillator start-up timer: 1024 external oscillator cycles
  localparam logic [9:0] OSC_START_LAST = 10'h3FF;
  // ==========================================================
  // register map
  localparam logic [1:0] ADDR_RESET_CAUSE_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_RESET_STATUS = 2'h1;
  // reset_cause_control field positions
  localparam int BIT_INT_PRIO_EN = 7;
  localparam int BIT_SW_BROWNOUT_EN = 6;
  localparam int BIT_RESET_INSTR_N = 4;
  localparam int BIT_WDOG_TIMEOUT_N = 3;
  localparam int BIT_POWER_DOWN_N = 2;
  localparam int BIT_POWER_ON_N = 1;
  localparam int BIT_BROWNOUT_N = 0;
  // reset_status field positions
  localparam int BIT_STAT_DETECT_ON = 0;
  localparam int BIT_STAT_REF_REQ = 1;
  localparam int BIT_STAT_CORE_HELD = 2;
  localparam int BIT_STAT_PIN_LEVEL = 3;
  // brownout enable modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_SLEEP_OFF = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  // ==========================================================
  // types
  typedef enum logic [2:0] {ST_POWER_ON, ST_BROWNOUT, ST_PUT, ST_OSC_START, ST_RUN} seq_e;
  // configuration word fields
  typedef struct packed {
    logic [1:0] brownout_enable_mode;
    logic [1:0] brownout_threshold_select;
    logic power_up_timer_disable_n;
    logic external_reset_pin_enable;
    logic crystal_mode;
  } cfg_s;
  // register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// >>> core/reset_ctl.sv
// reset cause register, brownout control, pin filter and power-up sequencing
// ==========================================================
// Function
// [R1] bit 7 turns two-level interrupt priority on
// [R2] software enable works only in mode 01
// [R3] software enable resets to 1 in mode 01
// [R4] reset instruction clears bit 4, firmware sets
// [R5] watchdog flag set by clear/sleep, cleared by timeout
// [R6] power-down flag set by clear, cleared by sleep
// [R7] power-on flag cleared by power-on only
// [R8] brownout flag cleared by brownout or power-on
// [R9] firmware re-arms both flags after power-on
// [R10] filtered low pin resets, pull-up enabled
// [R11] internal resets never drive the pin low
// [R12] disabled pin is a plain digital input
// [R13] supply rising gives a power-on reset
// [R14] long low supply resets until recovery
// [R15] low supply restarts the power-up timer
// [R16] brownout and timer enabled separately
// [R17] mode 10 disables detection during sleep
// [R18] modes 11 and 00 fixed by hardware
// [R19] detection needs reference stable first
// [R20] timer counts 2048 low-frequency ticks
// [R21] timer runs only when disable bit 0
// [R22] threshold only from configuration bits
// [R23] oscillator start-up waits 1024 crystal cycles
// [R24] reset release goes through two flops
`timescale 1ns/1ps
module reset_ctl (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire reset_ctl_pkg::reg_req_s i_reg,
  output logic [7:0] o_reg_rdata,
  // configuration word
  input wire reset_ctl_pkg::cfg_s i_cfg,
  // analog detectors and oscillators
  input wire logic i_supply_ok,
  input wire logic i_supply_low,
  input wire logic i_reference_stable_flag,
  input wire logic i_low_freq_osc_tick,
  input wire logic i_ext_osc_tick,
  // core events
  input wire logic i_reset_instr,
  input wire logic i_watchdog_timeout,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_sleep_instr,
  input wire logic i_sleeping,
  // external reset pin
  input wire logic i_external_reset_pin_n,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_pin_pullup_en,
  output logic o_pin_digital_in,
  // controls toward core and analog
  output logic o_core_rst_n,
  output logic o_interrupt_priority_enable,
  output logic o_brownout_detect_en,
  output logic o_fixed_voltage_reference_req,
  output logic [1:0] o_brownout_threshold_select
);
  import reset_ctl_pkg::*;

  // ==========================================================
  // state
  seq_e state; // reset sequencer state
  seq_e next_state;
  logic supply_ok_q; // previous supply detect level
  logic [7:0] low_cnt; // low supply duration counter
  logic [7:0] pin_cnt; // pin low filter counter
  logic pin_rst; // filtered pin reset level
  logic [10:0] put_cnt; // power-up timer count
  logic [9:0] osc_cnt; // start-up timer count
  logic soft_rst; // one-cycle internal reset hold
  logic sync1, sync2; // release synchroniser
  // register bits
  logic interrupt_priority_enable;
  logic software_brownout_enable;
  logic reset_instr_flag_n;
  logic watchdog_timeout_flag_n;
  logic power_down_flag_n;
  logic power_on_flag_n;
  logic brownout_flag_n;

  // ==========================================================
  // decode
  wire power_on_evt = i_sys_rst | (i_supply_ok & ~supply_ok_q); // [R13]
  wire mode_sw = (i_cfg.brownout_enable_mode == MODE_SOFTWARE);
  // detection enable per mode
  wire detect_en = mode_sw ? software_brownout_enable : // [R2]
                   (i_cfg.brownout_enable_mode == MODE_SLEEP_OFF) ? ~i_sleeping : // [R17]
                   (i_cfg.brownout_enable_mode == MODE_ALWAYS); // [R18]
  wire sensing = detect_en & i_reference_stable_flag; // [R19]
  wire low_seen = sensing & i_supply_low;
  wire brownout_evt = low_seen & (low_cnt == BROWNOUT_MIN_LAST); // [R14]
  wire pin_low = i_cfg.external_reset_pin_enable & ~i_external_reset_pin_n; // [R12]
  wire pin_evt = pin_low & ~pin_rst & (pin_cnt == PIN_FILTER_LAST); // [R10]
  wire wdog_reset = i_watchdog_timeout & ~i_sleeping;
  wire reg_wr_rc = i_reg.wr & (i_reg.addr == ADDR_RESET_CAUSE_CONTROL);
  wire put_done = i_low_freq_osc_tick & (put_cnt == PUT_LAST); // [R20]
  wire osc_done = i_ext_osc_tick & (osc_cnt == OSC_START_LAST); // [R23]
  wire core_hold = (state != ST_RUN) | pin_rst | soft_rst;
  wire sw_bit_read = mode_sw & software_brownout_enable; // [R2]
  wire [7:0] rc_read = {interrupt_priority_enable, sw_bit_read, 1'b0, reset_instr_flag_n,
                        watchdog_timeout_flag_n, power_down_flag_n, power_on_flag_n,
                        brownout_flag_n};
  wire [7:0] stat_read = {4'h0, i_external_reset_pin_n, core_hold, detect_en, detect_en};
  wire [7:0] rd_mux = (i_reg.addr == ADDR_RESET_CAUSE_CONTROL) ? rc_read :
                      (i_reg.addr == ADDR_RESET_STATUS) ? stat_read : 8'h00;

  // timer stage that follows a supply recovery
  function automatic seq_e after_supply(input cfg_s cfg);
    if (!cfg.power_up_timer_disable_n) begin
      after_supply = ST_PUT; // [R21] [R16]
    end else if (cfg.crystal_mode) begin
      after_supply = ST_OSC_START;
    end else begin
      after_supply = ST_RUN;
    end
  endfunction

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_POWER_ON: begin
        if (i_supply_ok) begin
          next_state = after_supply(i_cfg);
        end
      end
      ST_BROWNOUT: begin
        if (!i_supply_low) begin
          next_state = i_cfg.power_up_timer_disable_n ? ST_RUN : ST_PUT; // [R15]
        end
      end
      ST_PUT: begin
        if (put_done) begin
          next_state = i_cfg.crystal_mode ? ST_OSC_START : ST_RUN;
        end
      end
      ST_OSC_START: begin
        if (osc_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_POWER_ON;
    endcase
    if (brownout_evt) begin
      next_state = ST_BROWNOUT; // [R14] [R15]
    end
    if (!i_supply_ok) begin
      next_state = ST_POWER_ON;
    end
  end

  // ==========================================================
  // sequencer and counters
  always_ff @(posedge i_core_clk) begin
    supply_ok_q <= i_sys_rst ? 1'b0 : i_supply_ok;
    state <= i_sys_rst ? ST_POWER_ON : next_state;
  end

  // low supply duration filter
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !low_seen || brownout_evt) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // power-up timer, reinitialised outside its state
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || state != ST_PUT) begin
      put_cnt <= 11'h000; // [R15]
    end else if (i_low_freq_osc_tick) begin
      put_cnt <= put_cnt + 11'h001; // [R20]
    end
  end

  // oscillator start-up timer
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || state != ST_OSC_START) begin
      osc_cnt <= 10'h000;
    end else if (i_ext_osc_tick) begin
      osc_cnt <= osc_cnt + 10'h001; // [R23]
    end
  end

  // pin noise filter: short lows never reach the reset
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !pin_low) begin
      pin_cnt <= 8'h00;
      pin_rst <= 1'b0;
    end else begin
      pin_cnt <= (pin_cnt == PIN_FILTER_LAST) ? pin_cnt : pin_cnt + 8'h01;
      pin_rst <= pin_rst | pin_evt; // [R10]
    end
  end

  // internal resets hold the core for one cycle
  always_ff @(posedge i_core_clk) begin
    soft_rst <= ~i_sys_rst & (i_reset_instr | wdog_reset);
  end

  // release through two flops, assertion at once
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || core_hold) begin
      sync1 <= 1'b0; // [R24]
      sync2 <= 1'b0;
    end else begin
      sync1 <= 1'b1;
      sync2 <= sync1; // [R24]
    end
  end

  // ==========================================================
  // register bits
  always_ff @(posedge i_core_clk) begin
    if (power_on_evt) begin
      interrupt_priority_enable <= 1'b0;
    end else if (core_hold) begin
      interrupt_priority_enable <= 1'b0; // cleared by every reset
    end else if (reg_wr_rc) begin
      interrupt_priority_enable <= i_reg.wdata[BIT_INT_PRIO_EN]; // [R1]
    end
  end

  // software enable: loads from mode at power-on
  always_ff @(posedge i_core_clk) begin
    if (power_on_evt) begin
      software_brownout_enable <= mode_sw; // [R3]
    end else if (!mode_sw) begin
      software_brownout_enable <= 1'b0; // [R2]
    end else if (reg_wr_rc) begin
      software_brownout_enable <= i_reg.wdata[BIT_SW_BROWNOUT_EN];
    end
  end

  // cause flags; a hardware event wins over a firmware write
  always_ff @(posedge i_core_clk) begin
    if (power_on_evt) begin
      reset_instr_flag_n <= 1'b1; // [R4]
      watchdog_timeout_flag_n <= 1'b1; // [R5]
      power_down_flag_n <= 1'b1; // [R6]
      power_on_flag_n <= 1'b0; // [R7]
      brownout_flag_n <= 1'b0; // [R8]
    end else if (brownout_evt) begin
      reset_instr_flag_n <= 1'b1;
      watchdog_timeout_flag_n <= 1'b1;
      power_down_flag_n <= 1'b1;
      brownout_flag_n <= 1'b0; // [R8]
    end else begin
      if (i_reset_instr) begin
        reset_instr_flag_n <= 1'b0; // [R4]
      end else if (reg_wr_rc) begin
        reset_instr_flag_n <= i_reg.wdata[BIT_RESET_INSTR_N];
      end
      if (i_watchdog_timeout) begin
        watchdog_timeout_flag_n <= 1'b0; // [R5]
      end else if (i_watchdog_clear_instr || i_sleep_instr || pin_evt) begin
        watchdog_timeout_flag_n <= 1'b1; // [R5]
      end
      if (i_sleep_instr || (i_sleeping && (pin_evt || i_watchdog_timeout))) begin
        power_down_flag_n <= 1'b0; // [R6]
      end else if (i_watchdog_clear_instr) begin
        power_down_flag_n <= 1'b1; // [R6]
      end
      if (reg_wr_rc) begin
        power_on_flag_n <= i_reg.wdata[BIT_POWER_ON_N]; // [R7] [R9]
        brownout_flag_n <= i_reg.wdata[BIT_BROWNOUT_N]; // [R8] [R9]
      end
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
      o_core_rst_n <= 1'b0;
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
      o_pin_pullup_en <= 1'b0;
      o_pin_digital_in <= 1'b0;
      o_interrupt_priority_enable <= 1'b0;
      o_brownout_detect_en <= 1'b0;
      o_fixed_voltage_reference_req <= 1'b0;
      o_brownout_threshold_select <= 2'h0;
    end else begin
      o_reg_rdata <= i_reg.rd ? rd_mux : 8'h00;
      o_core_rst_n <= sync2; // [R24]
      o_pin_out <= 1'b0; // [R11]
      o_pin_oe <= 1'b0; // [R11]
      o_pin_pullup_en <= i_cfg.external_reset_pin_enable; // [R10]
      o_pin_digital_in <= ~i_cfg.external_reset_pin_enable & i_external_reset_pin_n; // [R12]
      o_interrupt_priority_enable <= interrupt_priority_enable; // [R1]
      o_brownout_detect_en <= sensing; // [R19]
      o_fixed_voltage_reference_req <= detect_en; // [R19]
      o_brownout_threshold_select <= i_cfg.brownout_threshold_select; // [R22]
    end
  end

  // ==========================================================
  // checking aids: length of the current sensed low supply
  logic [7:0] low_run; // consecutive low_seen cycles, saturating at the brownout limit
  // counts apart from the design filter so the brownout check does not reuse it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !low_seen) begin
      low_run <= 8'h00;
    end else if (low_run != BROWNOUT_MIN_LAST) begin
      low_run <= low_run + 8'h01;
    end
  end

  // ==========================================================
  // assertions
  sequence s_long_low;
    low_seen [*8];
  endsequence

  sequence s_recovered;
    !i_supply_low && state == ST_BROWNOUT && i_supply_ok && !brownout_evt;
  endsequence

  // pin high once, then held low for the whole filter length
  sequence s_pin_held;
    !pin_low ##1 pin_low [*8];
  endsequence

  sw_bit_mask_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R2]
    !mode_sw |=> !o_reg_rdata[BIT_SW_BROWNOUT_EN]) else $error("software enable seen");
  sw_bit_load_a: assert property (@(posedge i_core_clk) // [R3]
    i_sys_rst |=> software_brownout_enable == $past(mode_sw)) else $error("bad enable load");
  instr_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R4]
    i_reset_instr && !power_on_evt && !brownout_evt |=> !reset_instr_flag_n)
    else $error("reset instruction flag not cleared");
  sleep_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R6]
    i_sleep_instr && !brownout_evt && !power_on_evt && i_supply_ok
    |=> !power_down_flag_n && watchdog_timeout_flag_n || $past(i_watchdog_timeout))
    else $error("sleep flags wrong");
  power_on_flag_a: assert property (@(posedge i_core_clk) // [R7]
    power_on_evt |=> !power_on_flag_n) else $error("power-on flag not cleared");
  pin_never_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R11]
    !o_pin_oe) else $error("reset pin driven");
  low_reset_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R14]
    s_long_low ##0 (low_run == BROWNOUT_MIN_LAST && i_supply_ok) |=> state == ST_BROWNOUT)
    else $error("long low supply missed");
  put_restart_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R15]
    s_recovered |=> (state == ST_PUT) == !i_cfg.power_up_timer_disable_n || !$stable(i_cfg))
    else $error("timer not started after recovery");
  core_held_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R20]
    state == ST_PUT |-> ##2 !o_core_rst_n) else $error("core released while counting");
  sync_release_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R24]
    core_hold ##1 !core_hold [*3] |-> !o_core_rst_n ##1 o_core_rst_n)
    else $error("release not two flops");
  wdog_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R5]
    i_watchdog_timeout && !power_on_evt && !brownout_evt |=> !watchdog_timeout_flag_n)
    else $error("watchdog flag not cleared");
  brownout_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R8]
    brownout_evt |=> !brownout_flag_n) else $error("brownout flag not cleared");
  prio_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R1]
    reg_wr_rc && !core_hold && !power_on_evt
    |=> interrupt_priority_enable == $past(i_reg.wdata[BIT_INT_PRIO_EN]))
    else $error("priority bit not written");
  pin_filter_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R10]
    s_pin_held |-> !pin_rst ##1 pin_rst) else $error("pin filter length wrong");
  pin_off_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R12]
    !i_cfg.external_reset_pin_enable |=> !pin_rst) else $error("disabled pin gave reset");
  threshold_copy_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [R22]
    1'b1 |=> o_brownout_threshold_select == $past(i_cfg.brownout_threshold_select))
    else $error("threshold not from configuration");
endmodule

// >>> bench/test_reset_ctl.sv
// self-checking testbench for the reset cause and brownout control block
`timescale 1ns/1ps
module test_reset_ctl;
  import reset_ctl_pkg::*;
  // ==========================================================
  // signals
  logic i_core_clk;
  logic i_sys_rst;
  reg_req_s i_reg;
  cfg_s i_cfg;
  logic [7:0] o_reg_rdata;
  logic supply_ok, supply_low, ref_ok, sleeping, pin_n, lf_tick, tick_run;
  logic [3:0] ev; // 0 reset instr, 1 watchdog timeout, 2 watchdog clear, 3 sleep instr
  logic o_pin_out, o_pin_oe, o_pin_pullup_en, o_pin_digital_in, o_core_rst_n;
  logic o_ipe, o_det, o_ref_req;
  logic [1:0] o_thr;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] w;
  logic [1:0] m;
  logic en;
  // ==========================================================
  // design under test
  reset_ctl dut_u (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
    .i_cfg(i_cfg), .i_supply_ok(supply_ok), .i_supply_low(supply_low),
    .i_reference_stable_flag(ref_ok), .i_low_freq_osc_tick(lf_tick), .i_ext_osc_tick(lf_tick),
    .i_reset_instr(ev[0]), .i_watchdog_timeout(ev[1]), .i_watchdog_clear_instr(ev[2]),
    .i_sleep_instr(ev[3]), .i_sleeping(sleeping), .i_external_reset_pin_n(pin_n),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_pullup_en(o_pin_pullup_en),
    .o_pin_digital_in(o_pin_digital_in), .o_core_rst_n(o_core_rst_n),
    .o_interrupt_priority_enable(o_ipe), .o_brownout_detect_en(o_det),
    .o_fixed_voltage_reference_req(o_ref_req), .o_brownout_threshold_select(o_thr)
  );
  // ==========================================================
  // clock and oscillator ticks
  initial begin
    i_core_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) i_core_clk = ~i_core_clk;
  end
  // one-cycle tick every second cycle while enabled
  always @(posedge i_core_clk) begin
    lf_tick <= tick_run & ~lf_tick;
  end
  // ==========================================================
  // helpers
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // compare a byte
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  // compare a single bit
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // one-cycle write, then a quiet cycle
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    i_reg.addr <= a;
    i_reg.wdata <= d;
    i_reg.wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg.wr <= 1'b0;
    @(posedge i_core_clk);
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic check_rd(input logic [1:0] a, input logic [7:0] exp);
    i_reg.addr <= a;
    i_reg.rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg.rd <= 1'b0;
    #1;
    check_reg(o_reg_rdata, exp);
    @(posedge i_core_clk);
  endtask
  task automatic ev_pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge i_core_clk);
    ev <= 4'h0;
  endtask
  // core reset must keep one level for n cycles
  task automatic hold_chk(input int n, input logic lvl);
    repeat (n) begin
      @(negedge i_core_clk);
      check_bit(o_core_rst_n, lvl);
    end
    @(posedge i_core_clk);
  endtask
  // bounded wait for the core reset to reach a level
  task automatic wait_lvl(input logic lvl, input int lim);
    repeat (lim) begin
      @(negedge i_core_clk);
      if (o_core_rst_n === lvl) break;
    end
    check_bit(o_core_rst_n, lvl);
    @(posedge i_core_clk);
  endtask
  // expected readback after a firmware write with run-time flags at 1
  function automatic logic [7:0] exp_view(input logic [7:0] d, input logic [1:0] md);
    return {d[7], (md == MODE_SOFTWARE) & d[6], 1'b0, d[4], 2'b11, d[1:0]};
  endfunction
  // expected detector enable for a mode
  function automatic logic exp_det(input logic [1:0] md, input logic sw, input logic slp);
    return (md == MODE_ALWAYS) | ((md == MODE_SOFTWARE) & sw) | ((md == MODE_SLEEP_OFF) & ~slp);
  endfunction
  // watchdog against a hang
  initial begin
    #(CLK_PERIOD_NS * 40000);
    error_cnt++;
    $display("ERROR %0t run did not finish", $time);
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    w = 8'($urandom(32'h6FA5));
    i_sys_rst = 1'b1;
    i_reg = '0;
    i_cfg = '{MODE_SOFTWARE, 2'h1, 1'b0, 1'b1, 1'b1};
    {supply_ok, supply_low, sleeping, tick_run, ev} = '0;
    ref_ok = 1'b1;
    pin_n = 1'b1;
    tick(20);
    i_sys_rst <= 1'b0;
    tick(1);
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h5C); // power-on values
    check_bit(o_pin_pullup_en, 1'b1); // pull-up on
    supply_ok <= 1'b1;
    tick_run <= 1'b1;
    hold_chk(6000, 1'b0); // held through the power-up timer and into the start-up timer
    wait_lvl(1'b1, 300); // released after timers
    reg_wr(ADDR_RESET_CAUSE_CONTROL, 8'h73); // firmware re-arms flags
    reg_wr(ADDR_RESET_STATUS, 8'h00);
    reg_wr(2'h2, 8'h00);
    reg_wr(2'h3, 8'h00);
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h5F); // read-only bits kept
    check_rd(2'h2, 8'h00);
    check_rd(ADDR_RESET_STATUS, 8'h0B); // detector on, pin high
    // flag events
    ev_pulse(1);
    wait_lvl(1'b0, 10); // watchdog reset
    wait_lvl(1'b1, 20); // clean release
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h57); // timeout flag low
    ev_pulse(3);
    tick(2);
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h5B); // sleep flags
    ev_pulse(2);
    tick(2);
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h5F); // clear flags
    ev_pulse(0);
    wait_lvl(1'b0, 10); // instruction reset
    wait_lvl(1'b1, 20);
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h4F); // instruction flag low
    // external pin
    pin_n <= 1'b0;
    hold_chk(6, 1'b1); // short glitch ignored
    pin_n <= 1'b1;
    hold_chk(12, 1'b1); // still running
    pin_n <= 1'b0;
    wait_lvl(1'b0, 15); // long low resets
    check_bit(o_pin_oe, 1'b0); // pin never driven
    check_bit(o_pin_out, 1'b0); // pin output stays low
    pin_n <= 1'b1;
    wait_lvl(1'b1, 20); // release
    i_cfg.external_reset_pin_enable <= 1'b0;
    pin_n <= 1'b0;
    hold_chk(30, 1'b1); // plain input
    check_bit(o_pin_digital_in, 1'b0); // level seen
    check_bit(o_pin_pullup_en, 1'b0); // pull-up off
    pin_n <= 1'b1;
    tick(3);
    check_bit(o_pin_digital_in, 1'b1); // level seen
    // random register and mode traffic
    repeat (40) begin
      w = 8'($urandom);
      m = 2'($urandom);
      i_cfg.brownout_enable_mode <= m;
      i_cfg.brownout_threshold_select <= 2'($urandom);
      sleeping <= 1'($urandom);
      ref_ok <= 1'($urandom);
      reg_wr(ADDR_RESET_CAUSE_CONTROL, w);
      check_rd(ADDR_RESET_CAUSE_CONTROL, exp_view(w, m)); // readback
      check_bit(o_ipe, w[BIT_INT_PRIO_EN]); // priority output
      en = exp_det(m, w[BIT_SW_BROWNOUT_EN], sleeping);
      check_bit(o_ref_req, en); // detector mode
      check_bit(o_det, en & ref_ok); // waits for reference
      check_reg({6'h0, o_thr}, {6'h0, i_cfg.brownout_threshold_select}); // threshold
    end
    reg_wr(ADDR_RESET_CAUSE_CONTROL, 8'h13); // firmware re-arms flags
    // brownout with detection always on, timer off
    i_cfg <= '{MODE_ALWAYS, 2'h0, 1'b1, 1'b0, 1'b0};
    sleeping <= 1'b0;
    ref_ok <= 1'b1;
    supply_low <= 1'b1;
    hold_chk(30, 1'b1); // short dip ignored
    supply_low <= 1'b0;
    tick(2);
    supply_low <= 1'b1;
    wait_lvl(1'b0, 60); // long dip resets
    hold_chk(100, 1'b0); // held while low
    supply_low <= 1'b0;
    wait_lvl(1'b1, 20); // no timer delay
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h1E); // brownout flag low
    // dip again while the power-up timer counts
    i_cfg.power_up_timer_disable_n <= 1'b0;
    supply_low <= 1'b1;
    wait_lvl(1'b0, 60);
    supply_low <= 1'b0;
    tick(200);
    supply_low <= 1'b1;
    tick(60);
    supply_low <= 1'b0;
    hold_chk(3950, 1'b0); // timer restarted
    wait_lvl(1'b1, 300); // release after full count
    i_cfg.brownout_enable_mode <= MODE_OFF;
    supply_low <= 1'b1;
    hold_chk(100, 1'b1); // detection off
    check_bit(o_det, 1'b0); // detector off
    supply_low <= 1'b0;
    // second power-on outside software mode
    i_cfg.brownout_enable_mode <= MODE_SLEEP_OFF;
    i_sys_rst <= 1'b1;
    tick(3);
    i_sys_rst <= 1'b0;
    tick(1);
    check_rd(ADDR_RESET_CAUSE_CONTROL, 8'h1C); // software enable loads 0
    final_report();
  end
endmodule
